// *** inc/tbc_pkg.sv ***
`default_nettype none
package tbc_pkg;

  // Signed 16-bit signal word used along the whole chain.
  typedef logic signed [15:0] tbc_word_t;

  // Variable indexes of the accelerator signal chain.
  localparam logic [15:0] IDX_SHAPED_ACCEL = 16'h3211;
  localparam logic [15:0] IDX_ACCEL_GAIN = 16'h3213;
  localparam logic [15:0] IDX_ACCEL_BIAS = 16'h3214;
  localparam logic [15:0] IDX_ACCEL_POT = 16'h3215;
  localparam logic [15:0] IDX_FINAL_ACCEL = 16'h3216;
  localparam logic [15:0] IDX_SCRIPT_ACCEL = 16'h3218;
  localparam logic [15:0] IDX_FIRMWARE_ACCEL = 16'h3518;

  // Source type codes.
  localparam logic [2:0] SRC_POT_MIN = 3'h1;
  localparam logic [2:0] SRC_POT_MAX = 3'h4;
  localparam logic [2:0] SRC_SCRIPT = 3'h5;

  // Controller states in which the accelerator may act.
  localparam logic [7:0] STATE_RUN_A = 8'h05;
  localparam logic [7:0] STATE_RUN_B = 8'h0A;

  // Control mode codes.
  localparam logic [1:0] MODE_SPEED_EXPRESS = 2'h0;
  localparam logic [1:0] MODE_SPEED = 2'h1;
  localparam logic [1:0] MODE_TORQUE = 2'h2;

  // Signal levels: 100 %, -100 %, 0 % and the direction hints.
  localparam tbc_word_t FULL_SCALE = 16'sh7FFF;
  localparam tbc_word_t NEG_FULL_SCALE = 16'sh8001;
  localparam tbc_word_t ZERO_LEVEL = 16'sh0000;
  localparam tbc_word_t DIR_HINT_FWD = 16'sh0001;
  localparam tbc_word_t DIR_HINT_REV = 16'shFFFF;
  localparam tbc_word_t RUN_THRESHOLD = 16'sh0001;
  localparam tbc_word_t RUN_THRESHOLD_NEG = 16'shFFFF;

  // Gain divides by 128, which is a right shift by seven.
  localparam int GAIN_SHIFT = 7;
  localparam tbc_word_t UNITY_GAIN = 16'sh0080;

  // Saturation bounds in the wide working width.
  localparam logic signed [33:0] SAT_HI = 34'sh000007FFF;
  localparam logic signed [33:0] SAT_LO = 34'sh3FFFF8000;

  // Static configuration settings.
  typedef struct packed {
    logic [2:0] accelSourceType;
    logic [2:0] decelSourceType;
    logic pumpEnable;
    logic reverseLowerEnable;
    logic decelChainEnable;
    logic [1:0] controlMode;
  } tbc_cfg_s;

  // Gating conditions from the rest of the controller.
  typedef struct packed {
    logic interlockOn;
    logic faultZeroAccel;
    logic faultFullDecel;
    logic [7:0] mainState;
  } tbc_gate_s;

  // Sign-extends a signal word to the wide working width.
  function automatic logic signed [33:0] ext34(input tbc_word_t w);
    ext34 = {{18{w[15]}}, w};
  endfunction

  // Saturates a wide value to the signed 16-bit range.
  function automatic tbc_word_t sat16(input logic signed [33:0] v);
    if (v > SAT_HI) begin
      sat16 = FULL_SCALE;
    end else if (v < SAT_LO) begin
      sat16 = 16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction

  // True when a source type selects the pot path.
  function automatic logic isPotType(input logic [2:0] t);
    isPotType = (t >= SRC_POT_MIN) && (t <= SRC_POT_MAX);
  endfunction

endpackage
`default_nettype wire

// *** hw/tbc_pin_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbc_pin_sync #(
  parameter int W = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] level
);
  logic [W-1:0] stage1_q;
  logic [W-1:0] stage2_q;
  logic [W-1:0] stage3_q;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;
  logic [W-1:0] settled;

  // A bit only moves once the second and third stages agree.
  assign settled = ~(stage2_q ^ stage3_q);
  assign level_d = (stage2_q & settled) | (level_q & ~settled);
  assign level = level_q;

  // Three-stage chain; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      level_q <= '0;
    end else begin
      stage1_q <= pinIn;
      stage2_q <= stage1_q;
      stage3_q <= stage2_q;
      level_q <= level_d;
    end
  end
endmodule
`default_nettype wire

// *** hw/tbc_gain_stage.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbc_gain_stage
  import tbc_pkg::*;
(
  input wire tbc_word_t signalIn,
  input wire tbc_word_t gainValue,
  input wire tbc_word_t biasValue,
  output tbc_word_t result
);
  logic signed [31:0] product;
  logic signed [31:0] scaled;
  tbc_word_t gained;
  logic signed [33:0] biased;

  // Multiply, divide by 128 with an arithmetic shift, then saturate.
  assign product = signalIn * gainValue;
  assign scaled = product >>> GAIN_SHIFT;
  assign gained = sat16({{2{scaled[31]}}, scaled});

  // Add the signed bias and saturate instead of wrapping.
  assign biased = ext34(gained) + ext34(biasValue);
  assign result = sat16(biased);
endmodule
`default_nettype wire

// *** hw/tbc_command_chain.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbc_command_chain
  import tbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire tbc_cfg_s cfg,
  input wire tbc_gate_s gate,
  input wire logic forwardSwitch,
  input wire logic reverseSwitch,
  input wire logic [15:0] accelPotIn,
  input wire logic [15:0] decelPotIn,
  input wire tbc_word_t scriptAccelValue,
  input wire tbc_word_t scriptDecelValue,
  input wire tbc_word_t accelGainValue,
  input wire tbc_word_t accelBiasValue,
  output logic [15:0] accelPotSample,
  output logic [15:0] decelPotSample,
  output tbc_word_t firmwareMappedAccel,
  output tbc_word_t shapedAccelValue,
  output tbc_word_t finalAccelValue,
  output tbc_word_t mappedDecelValue,
  output tbc_word_t finalDecelValue,
  output tbc_word_t modeAccelCommand,
  output logic accelInvalid,
  output logic motorRun
);

  // Synchronised direction switches.
  logic [1:0] dirLevel;
  logic fwdOn;
  logic revOn;

  // Stage 1: captured pot samples.
  logic [15:0] accelPot_q;
  logic [15:0] decelPot_q;

  // Stage 2: mapped and selected signals.
  tbc_word_t firmwareAccel_q;
  tbc_word_t firmwareAccel_d;
  tbc_word_t selAccel_q;
  tbc_word_t selAccel_d;
  tbc_word_t mappedDecel_q;
  tbc_word_t mappedDecel_d;

  // Stage 3: shaped accel and final brake.
  tbc_word_t shaped_q;
  tbc_word_t shaped_d;
  tbc_word_t finalDecel_q;
  tbc_word_t finalDecel_d;

  // Stage 4: final accel command and validity.
  tbc_word_t finalAccel_q;
  tbc_word_t finalAccel_d;
  logic invalid_q;
  logic invalid_d;

  // Stage 5: control-mode command and run flag.
  tbc_word_t modeCmd_q;
  tbc_word_t modeCmd_d;
  logic motorRun_q;
  logic motorRun_d;

  // Combinational intermediates of the accel path.
  tbc_word_t accelMagnitude;
  tbc_word_t accelMapped;
  tbc_word_t accelHinted;
  tbc_word_t gainOut;
  tbc_word_t pumpLimited;
  tbc_word_t pumpChecked;
  logic speedMode;
  logic stateRun;
  logic accelBlocked;

  // Combinational intermediates of the brake path.
  tbc_word_t decelRaw;
  tbc_word_t decelSelected;
  tbc_word_t decelFaulted;

  // Combinational intermediates of the control-mode stage.
  logic signed [33:0] torqueWide;
  tbc_word_t torqueCmd;

  // Direction switches come from pins and are filtered first.
  tbc_pin_sync #(
    .W(2)
  ) u_dir_sync (
    .clk(clk),
    .reset(reset),
    .pinIn({reverseSwitch, forwardSwitch}),
    .level(dirLevel)
  );

  assign fwdOn = dirLevel[0];
  assign revOn = dirLevel[1];

  // Pot samples are captured on every rising clock edge.
  always_ff @(posedge clk) begin
    if (reset) begin
      accelPot_q <= 16'h0000;
      decelPot_q <= 16'h0000;
    end else begin
      accelPot_q <= accelPotIn;
      decelPot_q <= decelPotIn;
    end
  end

  // Raw magnitude: pot types give the sample held to 0..32767.
  assign accelMagnitude = !isPotType(cfg.accelSourceType) ? ZERO_LEVEL :
                          accelPot_q[15] ? FULL_SCALE :
                          tbc_word_t'(accelPot_q);

  // Mapping gives the magnitude the sign of the single active switch.
  assign accelMapped = (fwdOn && !revOn) ? accelMagnitude :
                       (revOn && !fwdOn) ? -accelMagnitude :
                       ZERO_LEVEL;

  // A zero mapping output is replaced by a small direction hint while either switch is on.
  assign accelHinted = (accelMapped != ZERO_LEVEL) ? accelMapped :
                       fwdOn ? DIR_HINT_FWD :
                       revOn ? DIR_HINT_REV :
                       ZERO_LEVEL;

  // Source type 5 takes the script value and drops the mapped one.
  assign selAccel_d = (cfg.accelSourceType == SRC_SCRIPT) ?
                      scriptAccelValue : accelHinted;
  assign firmwareAccel_d = accelMagnitude;

  // Brake type processing treats the pot sample as a signed word.
  assign decelRaw = isPotType(cfg.decelSourceType) ?
                    tbc_word_t'(decelPot_q) : ZERO_LEVEL;

  // Brake source type 5 takes the script value instead.
  assign decelSelected = (cfg.decelSourceType == SRC_SCRIPT) ?
                         scriptDecelValue : decelRaw;

  // Negative brake is meaningless, so the limiter floors it at zero.
  assign mappedDecel_d = (decelSelected < ZERO_LEVEL) ? ZERO_LEVEL :
                         decelSelected;

  // Stage 2 registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      firmwareAccel_q <= ZERO_LEVEL;
      selAccel_q <= ZERO_LEVEL;
      mappedDecel_q <= ZERO_LEVEL;
    end else begin
      firmwareAccel_q <= firmwareAccel_d;
      selAccel_q <= selAccel_d;
      mappedDecel_q <= mappedDecel_d;
    end
  end

  // Gain and bias nodes.
  tbc_gain_stage u_gain (
    .signalIn(selAccel_q),
    .gainValue(accelGainValue),
    .biasValue(accelBiasValue),
    .result(gainOut)
  );

  // Pump limiter: with the pump enabled it caps at 100 %, floors only for lowering.
  assign pumpLimited = !cfg.pumpEnable ? gainOut :
                       (gainOut > FULL_SCALE) ? FULL_SCALE :
                       (cfg.reverseLowerEnable &&
                        gainOut < NEG_FULL_SCALE) ? NEG_FULL_SCALE :
                       gainOut;
  assign shaped_d = pumpLimited;

  // Full-brake fault forces 100 %, the chain enable gates it all.
  assign decelFaulted = gate.faultFullDecel ? FULL_SCALE :
                        mappedDecel_q;
  assign finalDecel_d = cfg.decelChainEnable ? decelFaulted :
                        ZERO_LEVEL;

  // Stage 3 registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      shaped_q <= ZERO_LEVEL;
      finalDecel_q <= ZERO_LEVEL;
    end else begin
      shaped_q <= shaped_d;
      finalDecel_q <= finalDecel_d;
    end
  end

  // Mode and state decoding.
  assign speedMode = (cfg.controlMode == MODE_SPEED_EXPRESS) ||
                     (cfg.controlMode == MODE_SPEED);
  assign stateRun = (gate.mainState == STATE_RUN_A) ||
                    (gate.mainState == STATE_RUN_B);

  // Both direction switches at once is an invalid accel input.
  assign invalid_d = fwdOn && revOn;

  // A pump may not run backwards in either speed mode.
  assign pumpChecked = (speedMode && cfg.pumpEnable &&
                        shaped_q < ZERO_LEVEL) ? ZERO_LEVEL :
                       shaped_q;

  // Any blocking condition forces the final accel command to zero.
  assign accelBlocked = !gate.interlockOn || gate.faultZeroAccel ||
                        !stateRun || invalid_d;
  assign finalAccel_d = accelBlocked ? ZERO_LEVEL : pumpChecked;

  // Stage 4 registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      finalAccel_q <= ZERO_LEVEL;
      invalid_q <= 1'b0;
    end else begin
      finalAccel_q <= finalAccel_d;
      invalid_q <= invalid_d;
    end
  end

  // Torque mode subtracts twice the brake, saturating the result.
  assign torqueWide = ext34(finalAccel_q) -
                      (ext34(finalDecel_q) <<< 1);
  assign torqueCmd = sat16(torqueWide);

  // Speed modes let any brake override the accel command.
  assign modeCmd_d = !speedMode ? torqueCmd :
                     (finalDecel_q != ZERO_LEVEL) ? ZERO_LEVEL :
                     finalAccel_q;

  // The motor only spins when the command magnitude exceeds 1.
  assign motorRun_d = (finalAccel_q > RUN_THRESHOLD) ||
                      (finalAccel_q < RUN_THRESHOLD_NEG);

  // Stage 5 registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      modeCmd_q <= ZERO_LEVEL;
      motorRun_q <= 1'b0;
    end else begin
      modeCmd_q <= modeCmd_d;
      motorRun_q <= motorRun_d;
    end
  end

  // Every output comes from a register.
  assign accelPotSample = accelPot_q;
  assign decelPotSample = decelPot_q;
  assign firmwareMappedAccel = firmwareAccel_q;
  assign shapedAccelValue = shaped_q;
  assign finalAccelValue = finalAccel_q;
  assign mappedDecelValue = mappedDecel_q;
  assign finalDecelValue = finalDecel_q;
  assign modeAccelCommand = modeCmd_q;
  assign accelInvalid = invalid_q;
  assign motorRun = motorRun_q;

endmodule
`default_nettype wire

// *** testbench/tbc_command_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbc_command_monitor
  import tbc_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire tbc_cfg_s cfg,
  input wire tbc_gate_s gate,
  input wire logic forwardSwitch,
  input wire logic reverseSwitch,
  input wire logic [15:0] accelPotIn,
  input wire logic [15:0] accelPotSample,
  input wire tbc_word_t shapedAccelValue,
  input wire tbc_word_t finalAccelValue,
  input wire tbc_word_t finalDecelValue,
  input wire tbc_word_t modeAccelCommand,
  input wire logic accelInvalid,
  input wire logic motorRun
);
  logic signed [17:0] tDiff;
  tbc_word_t tSat;

  // Torque command: accel minus twice the brake, saturated to 16 bits.
  assign tDiff = {{2{finalAccelValue[15]}}, finalAccelValue}
    - {finalDecelValue[15], finalDecelValue, 1'b0};
  assign tSat = (!tDiff[17] && tDiff[16:15] != 2'h0) ? FULL_SCALE
    : (tDiff[17] && tDiff[16:15] != 2'h3) ? 16'sh8000 : tDiff[15:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Each output follows its cause with the pipeline latency.
  pot_copy_a: assert property (
    !$past(reset) |-> accelPotSample == $past(accelPotIn))
    else $error("pot sample copy wrong");
  run_flag_a: assert property (
    !$past(reset) |-> motorRun == ($past(finalAccelValue) > RUN_THRESHOLD
    || $past(finalAccelValue) < RUN_THRESHOLD_NEG))
    else $error("run flag wrong");
  gate_zero_a: assert property (
    !$past(reset) && $past(!gate.interlockOn || gate.faultZeroAccel
    || (gate.mainState != STATE_RUN_A && gate.mainState != STATE_RUN_B))
    |-> finalAccelValue == ZERO_LEVEL)
    else $error("gated accel not zero");
  pump_neg_a: assert property (
    !$past(reset) && $past(cfg.pumpEnable && !cfg.controlMode[1]
    && shapedAccelValue < 0) && !cfg.controlMode[1]
    |-> finalAccelValue == ZERO_LEVEL)
    else $error("negative pump command passed");
  both_switch_a: assert property (
    (forwardSwitch && reverseSwitch) [*7] |=> accelInvalid)
    else $error("both switches not invalid");
  decel_off_a: assert property (
    !$past(reset) && !$past(cfg.decelChainEnable)
    |-> finalDecelValue == ZERO_LEVEL)
    else $error("disabled brake not zero");
  full_decel_a: assert property (
    !$past(reset) && $past(cfg.decelChainEnable && gate.faultFullDecel)
    |-> finalDecelValue == FULL_SCALE)
    else $error("full brake not full scale");
  brake_wins_a: assert property (
    !$past(reset) && $past(!cfg.controlMode[1] && finalDecelValue != 0)
    && !cfg.controlMode[1] |-> modeAccelCommand == ZERO_LEVEL)
    else $error("brake did not override accel");
  torque_sub_a: assert property (
    !$past(reset) && $past(cfg.controlMode[1]) && cfg.controlMode[1]
    |-> modeAccelCommand == $past(tSat))
    else $error("torque command wrong");
endmodule
`default_nettype wire

// *** testbench/tbc_pedal_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbc_pedal_model
  import tbc_pkg::*;
(
  output var logic [15:0] accelPot,
  output var logic [15:0] decelPot,
  output var logic fwdPin,
  output var logic revPin,
  output var tbc_word_t scrAccel,
  output var tbc_word_t scrDecel,
  output var tbc_word_t gainVal,
  output var tbc_word_t biasVal
);
  // Pedals rest released, with unity gain until the script writes.
  initial begin
    {accelPot, decelPot, fwdPin, revPin, scrAccel, scrDecel, biasVal} = 82'h0;
    gainVal = UNITY_GAIN;
  end

  // Sets pedals, switch pins {fwd, rev} and script variables at once.
  task automatic apply(input logic [15:0] ap, input logic [15:0] dp,
    input logic [1:0] sw, input tbc_word_t sa, input tbc_word_t sd,
    input tbc_word_t g, input tbc_word_t b);
    {accelPot, decelPot, fwdPin, revPin} = {ap, dp, sw};
    {scrAccel, scrDecel, gainVal, biasVal} = {sa, sd, g, b};
  endtask
endmodule
`default_nettype wire

// *** testbench/tbc_command_chain_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tbc_command_chain_tb;
  import tbc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  tbc_cfg_s cfg = '0;
  tbc_gate_s gate = '0;
  logic fwdPin, revPin, accelInvalid, motorRun;
  logic [15:0] accelPot, decelPot;
  tbc_word_t scrAccel, scrDecel, gainVal, biasVal;
  tbc_word_t shaped, finalA, mappedD, finalD, modeCmd;
  logic [15:0] accelPotS, decelPotS;
  tbc_word_t fwMapped;
  int fail_count = 0;
  int checks = 0;
  int cycles = 0;

  tbc_pedal_model i_tbc_pedal_model (.accelPot(accelPot),
    .decelPot(decelPot), .fwdPin(fwdPin), .revPin(revPin),
    .scrAccel(scrAccel), .scrDecel(scrDecel), .gainVal(gainVal),
    .biasVal(biasVal));

  tbc_command_chain i_tbc_command_chain (.clk(clk), .reset(reset),
    .cfg(cfg), .gate(gate), .forwardSwitch(fwdPin), .reverseSwitch(revPin),
    .accelPotIn(accelPot), .decelPotIn(decelPot),
    .scriptAccelValue(scrAccel), .scriptDecelValue(scrDecel),
    .accelGainValue(gainVal), .accelBiasValue(biasVal),
    .accelPotSample(accelPotS), .decelPotSample(decelPotS),
    .firmwareMappedAccel(fwMapped),
    .shapedAccelValue(shaped), .finalAccelValue(finalA),
    .mappedDecelValue(mappedD), .finalDecelValue(finalD),
    .modeAccelCommand(modeCmd), .accelInvalid(accelInvalid),
    .motorRun(motorRun));

  // Clock, and a cycle ceiling that cuts a hang short.
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      results();
    end
  end

  // Saturates a wide value to the signed 16-bit range.
  function automatic tbc_word_t sat(input logic signed [33:0] v);
    return v > 34'sh7FFF ? FULL_SCALE : v < -34'sh8000 ? 16'sh8000 : v[15:0];
  endfunction

  // True for the source types that read the pot.
  function automatic logic potType(input logic [2:0] t);
    return t >= SRC_POT_MIN && t <= SRC_POT_MAX;
  endfunction

  // Expected accel magnitude: pot types only, held to 0..32767.
  function automatic tbc_word_t expMag();
    if (!potType(cfg.accelSourceType)) return ZERO_LEVEL;
    return accelPot[15] ? FULL_SCALE : tbc_word_t'(accelPot);
  endfunction

  // Expected accel after source, direction hint, gain, bias and pump.
  function automatic tbc_word_t expShaped();
    logic signed [33:0] m;
    tbc_word_t s;
    m = expMag();
    if (revPin) m = -m;
    if (fwdPin == revPin) m = 0;
    if (m == 0) m = fwdPin ? 1 : revPin ? -1 : 0;
    if (cfg.accelSourceType == SRC_SCRIPT) m = scrAccel;
    s = sat((m * gainVal) >>> GAIN_SHIFT);
    s = sat(34'(s) + 34'(biasVal));
    if (cfg.pumpEnable && cfg.reverseLowerEnable && s < -32767) begin
      s = NEG_FULL_SCALE;
    end
    return s;
  endfunction

  // Expected command after the control-mode stage.
  function automatic tbc_word_t expMode(input tbc_word_t a,
    input tbc_word_t d);
    if (cfg.controlMode[1]) return sat(34'(a) - 34'(d) * 2);
    return d != 0 ? ZERO_LEVEL : a;
  endfunction

  // Draws a script value, often a boundary of the signed range.
  function automatic tbc_word_t pick();
    case ($urandom_range(3, 0))
      0: return FULL_SCALE;
      1: return 16'sh8000;
      2: return ZERO_LEVEL;
      default: return 16'($urandom);
    endcase
  endfunction

  // Counts a comparison and reports a mismatch at once.
  task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Lets the pipeline settle, then checks every stage output.
  task automatic runCase();
    tbc_word_t sh, fa, md, fd;
    repeat (12) @(negedge clk);
    sh = expShaped();
    fa = sh;
    if (cfg.pumpEnable && !cfg.controlMode[1] && sh < 0) fa = 0;
    if (!gate.interlockOn || gate.faultZeroAccel || fwdPin && revPin) fa = 0;
    if (gate.mainState != STATE_RUN_A && gate.mainState != STATE_RUN_B) fa = 0;
    md = cfg.decelSourceType == SRC_SCRIPT ? scrDecel :
      potType(cfg.decelSourceType) ? decelPot : ZERO_LEVEL;
    if (md < 0) md = 0;
    fd = gate.faultFullDecel ? FULL_SCALE : md;
    if (!cfg.decelChainEnable) fd = 0;
    chkWord(accelPotS, accelPot);
    chkWord(decelPotS, decelPot);
    chkWord(fwMapped, expMag());
    chkWord(shaped, sh);
    chkWord(finalA, fa);
    chkWord(mappedD, md);
    chkWord(finalD, fd);
    chkWord(modeCmd, expMode(fa, fd));
    chkWord({15'h0, motorRun}, {15'h0, fa > 1 || fa < -1});
    chkWord({15'h0, accelInvalid}, {15'h0, fwdPin && revPin});
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Reset, the plain walk, the reverse hint at the run boundary, then random.
  initial begin
    void'($urandom(32'h8862));
    repeat (8) @(negedge clk);
    reset = 1'b0;
    cfg = '{3'h1, SRC_SCRIPT, 1'b0, 1'b0, 1'b1, MODE_SPEED};
    gate = '{1'b1, 1'b0, 1'b0, STATE_RUN_A};
    i_tbc_pedal_model.apply(16'h03E8, 16'h0, 2'h2, 0, 0, UNITY_GAIN, 0);
    runCase();
    i_tbc_pedal_model.apply(16'h0, 16'h0, 2'h1, 0, 0, UNITY_GAIN, 0);
    runCase();
    // A second reset in mid-run, then a pot sample above full scale.
    reset = 1'b1;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    i_tbc_pedal_model.apply(16'h9000, 16'h0, 2'h2, 0, 0, UNITY_GAIN, 0);
    runCase();
    // Random cases; source types cover every code, 0, 6 and 7 included.
    repeat (150) begin
      cfg = 11'($urandom);
      gate = 11'($urandom);
      gate.interlockOn = $urandom_range(7, 0) != 0;
      gate.faultZeroAccel = $urandom_range(3, 0) == 0;
      if ($urandom_range(1, 0)) gate.mainState = STATE_RUN_B;
      i_tbc_pedal_model.apply(16'($urandom_range(32767, 0)), 16'($urandom),
        2'($urandom), pick(), pick(),
        $urandom_range(1, 0) ? UNITY_GAIN : pick(), pick());
      runCase();
    end
    results();
  end
endmodule

bind tbc_command_chain tbc_command_monitor i_tbc_command_monitor (
  .clk(clk), .reset(reset), .cfg(cfg), .gate(gate),
  .forwardSwitch(forwardSwitch), .reverseSwitch(reverseSwitch),
  .accelPotIn(accelPotIn), .accelPotSample(accelPotSample),
  .shapedAccelValue(shapedAccelValue), .finalAccelValue(finalAccelValue),
  .finalDecelValue(finalDecelValue), .modeAccelCommand(modeAccelCommand),
  .accelInvalid(accelInvalid), .motorRun(motorRun));
`default_nettype wire
